// ===== design/td_defs.vh
`ifndef TD_DEFS_VH
`define TD_DEFS_VH
// Register byte addresses on the Wishbone bus.
`define TD_ADR_CTRL    8'h00
`define TD_ADR_OLSET   8'h04
`define TD_ADR_VIBSET  8'h08
`define TD_ADR_PFSET   8'h0c
`define TD_ADR_NOTCH1  8'h10
`define TD_ADR_NOTCH2  8'h14
`define TD_ADR_NOTCH3  8'h18
`define TD_ADR_EVENTS  8'h1c
`define TD_ADR_STATUS  8'h20
// Control register field positions.
`define TD_CTRL_SEL    0
`define TD_CTRL_D1     1
`define TD_CTRL_ACLR   2
// Reset values.
`define TD_RST_CTRL    2'h0
`define TD_RST_OLSET   16'h01f4
`define TD_RST_VIBSET  16'h0032
`define TD_RST_PFSET   16'h0014
`define TD_RST_NOTCH1  16'h1194
`define TD_RST_NOTCH2  16'h1194
`define TD_RST_NOTCH3  16'h1194
// Timing: tick period in microseconds, clock rate, commit spacing.
`define TD_TICK_US     17'h0_03e8
`define TD_CLK_MHZ     17'h0_0064
`define TD_HOUR_S      22'h00_0e10
`define TD_MS_PER_S    22'h00_03e8
// Load ratio levels in percent.
`define TD_OL_ENTRY    8'h5f
`define TD_OL_TARGET   8'h46
`define TD_OL_SPIKE    8'hc8
`define TD_FULL_PCT    8'h64
`define TD_PF_LOAD_LIM 8'h50
`define TD_PF_TORQUE   8'h50
// Alarm codes in BCD, major digit pair then minor digit.
`define TD_ALM_NONE    12'h000
`define TD_ALM_UV      12'h102
`define TD_ALM_PF      12'h103
`endif

// ===== design/td_delay_gate.v
`timescale 1ns/1ns
// Holds back a status level by a programmable number of ticks while
// the hold is enabled; otherwise passes it through one flop later.
module td_delay_gate (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        reset,
  // Timing and control.
  input  wire        tick,
  input  wire        hold_en,
  input  wire [15:0] delay_ms,
  // Status in and out.
  input  wire        raw,
  output reg         gated_q
);
  reg [15:0] cnt_q;  // Ticks since the raw level rose.

  // The count restarts whenever the raw level drops, so a bouncing
  // status never sums partial waits into an early assertion.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      cnt_q   <= 16'h0000;
      gated_q <= 1'b0;
    end else if (!raw) begin
      cnt_q   <= 16'h0000;
      gated_q <= 1'b0;
    end else if (!hold_en) begin
      gated_q <= 1'b1;
    end else if (cnt_q >= delay_ms) begin
      gated_q <= 1'b1;
    end else if (tick) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end
endmodule // td_delay_gate

// ===== design/td_supervisor.v
// The register offsets and the Wishbone slave port were left to the implementer.
`timescale 1ns/1ns
`include "td_defs.vh"
module td_supervisor #(
  parameter [16:0] TICK_CYCLES = `TD_TICK_US * `TD_CLK_MHZ,
  parameter [21:0] HOUR_TICKS  = `TD_HOUR_S * `TD_MS_PER_S
) (
  // Clock and reset.
  input  wire        clk_sys,
  input  wire        reset,
  // Wishbone classic slave.
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [7:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // Drive state from the servo core, same clock.
  input  wire        pos_mode,
  input  wire [7:0]  load_ratio,
  input  wire        motor_stopped,
  input  wire        in_position_raw,
  input  wire        zero_speed_raw,
  input  wire        brake_request,
  // Resonance detector, same clock.
  input  wire        res_valid,
  input  wire [15:0] res_freq,
  input  wire [15:0] res_level,
  // Power pins, asynchronous.
  input  wire        mains_ok_pin,
  input  wire        bus_uv_pin,
  // Status outputs.
  output wire        in_position,
  output wire        zero_speed,
  output reg         tough_drive_active,
  output reg         brake_interlock,
  output reg  [7:0]  torque_limit,
  output reg  [11:0] alarm_code,
  // Nonvolatile commit of notch one and two.
  output reg         nv_write,
  output reg  [15:0] nv_notch1,
  output reg  [15:0] nv_notch2
);
  // Power-failure states, one-hot.
  localparam [2:0] PF_IDLE  = 3'b001;
  localparam [2:0] PF_RIDE  = 3'b010;
  localparam [2:0] PF_ALARM = 3'b100;

  reg  [1:0]  ctrl_q;       // Select and output-select bits.
  reg  [15:0] olset_q;      // Longest in_position delay in ms.
  reg  [15:0] vibset_q;     // Resonance detection level.
  reg  [15:0] pfset_q;      // Power-loss judgment time in ms.
  reg  [15:0] notch1_q;     // Notch filter one frequency.
  reg  [15:0] notch2_q;     // Notch filter two frequency.
  reg  [15:0] notch3_q;     // Notch filter three frequency.
  reg  [15:0] events_q;     // Activation counter.
  reg         ack_q;        // Bus answer, one cycle.
  reg  [16:0] div_q;        // Millisecond divider.
  reg         tick_q;       // One-cycle millisecond enable.
  reg  [2:0]  mains_s;      // Mains-ok synchroniser.
  reg  [2:0]  uv_s;         // Undervoltage synchroniser.
  reg         mains_ok_q;   // Filtered mains level.
  reg         uv_q;         // Filtered undervoltage level.
  reg         ol_q;         // Overload handling active.
  reg  [2:0]  pf_q;         // Power-failure state.
  reg  [15:0] pf_ms_q;      // Length of the current loss.
  reg         dirty_q;      // Detector retuned a notch since last commit.
  reg  [21:0] hour_q;       // Ticks since last commit.
  reg         nv_ok_q;      // An hour has passed since commit.
  reg  [2:0]  pf_d;
  reg  [15:0] ol_delay;
  reg         vib_hit;
  reg         vib_pick2;
  wire        wr_req;
  wire        sel_en;
  wire        ol_cond;
  wire        ol_start;
  wire        pf_start;
  wire        aclr;

  // True when f lies within thirty percent of n.
  function within30;
    input [15:0] f;
    input [15:0] n;
    reg   [15:0] d;
    begin
      d = (f > n) ? f - n : n - f;
      within30 = ({4'h0, d} * 20'd10) <= ({4'h0, n} * 20'd3);
    end
  endfunction

  // Distance between two frequencies.
  function [15:0] absdiff;
    input [15:0] a;
    input [15:0] b;
    begin
      absdiff = (a > b) ? a - b : b - a;
    end
  endfunction

  // Byte-lane merge for a 16-bit register on a 32-bit bus.
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] dat;
    input [3:0]  sel;
    begin
      merge16[7:0]  = sel[0] ? dat[7:0]  : old[7:0];
      merge16[15:8] = sel[1] ? dat[15:8] : old[15:8];
    end
  endfunction

  // The bus answers every access one cycle after the strobe, mapped or
  // not, so a master never hangs on a stray address.
  assign wb_ack_o = ack_q;
  assign wr_req   = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_q;
  assign sel_en   = ctrl_q[`TD_CTRL_SEL];
  assign aclr     = wr_req & (wb_adr_i == `TD_ADR_CTRL) & wb_sel_i[0]
                    & wb_dat_i[`TD_CTRL_ACLR];

  // Registered acknowledge and read data.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ack_q    <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      ack_q <= wb_cyc_i & wb_stb_i & ~ack_q;
      case (wb_adr_i)
        `TD_ADR_CTRL:   wb_dat_o <= {30'h0000_0000, ctrl_q};
        `TD_ADR_OLSET:  wb_dat_o <= {16'h0000, olset_q};
        `TD_ADR_VIBSET: wb_dat_o <= {16'h0000, vibset_q};
        `TD_ADR_PFSET:  wb_dat_o <= {16'h0000, pfset_q};
        `TD_ADR_NOTCH1: wb_dat_o <= {16'h0000, notch1_q};
        `TD_ADR_NOTCH2: wb_dat_o <= {16'h0000, notch2_q};
        `TD_ADR_NOTCH3: wb_dat_o <= {16'h0000, notch3_q};
        `TD_ADR_EVENTS: wb_dat_o <= {16'h0000, events_q};
        `TD_ADR_STATUS: wb_dat_o <= {16'h0000, ol_q, pf_q, alarm_code};
        default:        wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Plain settings written by software only.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ctrl_q   <= `TD_RST_CTRL;
      olset_q  <= `TD_RST_OLSET;
      vibset_q <= `TD_RST_VIBSET;
      pfset_q  <= `TD_RST_PFSET;
      notch3_q <= `TD_RST_NOTCH3;
    end else if (wr_req) begin
      case (wb_adr_i)
        `TD_ADR_CTRL: begin
          if (wb_sel_i[0]) begin
            ctrl_q <= wb_dat_i[1:0];
          end
        end
        `TD_ADR_OLSET:  olset_q  <= merge16(olset_q, wb_dat_i, wb_sel_i);
        `TD_ADR_VIBSET: vibset_q <= merge16(vibset_q, wb_dat_i, wb_sel_i);
        `TD_ADR_PFSET:  pfset_q  <= merge16(pfset_q, wb_dat_i, wb_sel_i);
        // Only software reaches notch three.
        `TD_ADR_NOTCH3: notch3_q <= merge16(notch3_q, wb_dat_i,
                                            wb_sel_i);
        default: begin
        end
      endcase
    end
  end

  // Millisecond enable; all slow timing counts these pulses.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      div_q  <= 17'h0_0000;
      tick_q <= 1'b0;
    end else if (div_q == TICK_CYCLES - 17'h0_0001) begin
      div_q  <= 17'h0_0000;
      tick_q <= 1'b1;
    end else begin
      div_q  <= div_q + 17'h0_0001;
      tick_q <= 1'b0;
    end
  end

  // Three-flop synchronisers; a level is taken only once the last two
  // stages agree, which also rejects a single-cycle glitch.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      mains_s    <= 3'h7;
      uv_s       <= 3'h0;
      mains_ok_q <= 1'b1;
      uv_q       <= 1'b0;
    end else begin
      mains_s <= {mains_s[1:0], mains_ok_pin};
      uv_s    <= {uv_s[1:0], bus_uv_pin};
      if (mains_s[1] == mains_s[2]) begin
        mains_ok_q <= mains_s[2];
      end
      if (uv_s[1] == uv_s[2]) begin
        uv_q <= uv_s[2];
      end
    end
  end

  // Overload handling runs only when selected, in position control,
  // in the band below a spike and with the motor moving.
  assign ol_cond = sel_en
                   & pos_mode
                   & (load_ratio >= `TD_OL_ENTRY)
                   & (load_ratio <= `TD_OL_SPIKE)
                   & ~motor_stopped;
  assign ol_start = ol_cond & ~ol_q;

  // Delay grows with the excess over the target ratio, bounded by the
  // software limit so the controller never times out waiting.
  always @* begin
    ol_delay = {6'h00, load_ratio - `TD_OL_TARGET, 2'b00};
    if (ol_delay > olset_q) begin
      ol_delay = olset_q;
    end
  end

  // Overload state and the selected active output.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      ol_q               <= 1'b0;
      tough_drive_active <= 1'b0;
    end else begin
      ol_q               <= ol_cond;
      tough_drive_active <= ol_cond & ctrl_q[`TD_CTRL_D1];
    end
  end

  // Both completion outputs share one computed delay.
  td_delay_gate u_inp_gate (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .tick     (tick_q),
    .hold_en  (ol_q),
    .delay_ms (ol_delay),
    .raw      (in_position_raw),
    .gated_q  (in_position)
  );

  td_delay_gate u_zsp_gate (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .tick     (tick_q),
    .hold_en  (ol_q),
    .delay_ms (ol_delay),
    .raw      (zero_speed_raw),
    .gated_q  (zero_speed)
  );

  // Vibration trigger: strong enough and close to one of two notches.
  always @* begin
    vib_hit = sel_en & res_valid & (res_level >= vibset_q)
              & (within30(res_freq, notch1_q)
                 | within30(res_freq, notch2_q));
    vib_pick2 = absdiff(res_freq, notch2_q)
                < absdiff(res_freq, notch1_q);
  end

  // Notch one and two: the detector wins over a software write in the
  // same cycle, since losing a live retune could leave oscillation.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      notch1_q <= `TD_RST_NOTCH1;
      notch2_q <= `TD_RST_NOTCH2;
    end else if (vib_hit) begin
      if (vib_pick2) begin
        notch2_q <= res_freq;
      end else begin
        notch1_q <= res_freq;
      end
    end else if (wr_req && wb_adr_i == `TD_ADR_NOTCH1) begin
      notch1_q <= merge16(notch1_q, wb_dat_i, wb_sel_i);
    end else if (wr_req && wb_adr_i == `TD_ADR_NOTCH2) begin
      notch2_q <= merge16(notch2_q, wb_dat_i, wb_sel_i);
    end
  end

  // Commit pacing: retunes take effect at once but wear on storage is
  // bounded by writing at most once per hour; the first may go at once.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      dirty_q   <= 1'b0;
      hour_q    <= 22'h00_0000;
      nv_ok_q   <= 1'b1;
      nv_write  <= 1'b0;
      nv_notch1 <= 16'h0000;
      nv_notch2 <= 16'h0000;
    end else begin
      nv_write <= 1'b0;
      if (dirty_q && nv_ok_q && !vib_hit) begin
        nv_write  <= 1'b1;
        nv_notch1 <= notch1_q;
        nv_notch2 <= notch2_q;
        dirty_q   <= 1'b0;
        nv_ok_q   <= 1'b0;
        hour_q    <= 22'h00_0000;
      end else begin
        if (vib_hit) begin
          dirty_q <= 1'b1;
        end
        if (tick_q && !nv_ok_q) begin
          if (hour_q == HOUR_TICKS - 22'h00_0001) begin
            nv_ok_q <= 1'b1;
          end else begin
            hour_q <= hour_q + 22'h00_0001;
          end
        end
      end
    end
  end

  // Power-failure next state.
  assign pf_start = (pf_q == PF_IDLE) & ~mains_ok_q & sel_en;
  always @* begin
    pf_d = pf_q;
    case (pf_q)
      PF_IDLE: begin
        if (!mains_ok_q) begin
          pf_d = sel_en ? PF_RIDE : PF_ALARM;
        end
      end
      PF_RIDE: begin
        if (uv_q) begin
          pf_d = PF_ALARM;
        end else if (pf_ms_q > pfset_q) begin
          pf_d = PF_ALARM;
        end else if (mains_ok_q) begin
          pf_d = PF_IDLE;
        end
      end
      PF_ALARM: begin
        if (aclr && mains_ok_q) begin
          pf_d = PF_IDLE;
        end
      end
      default: pf_d = PF_IDLE;
    endcase
  end

  // Power-failure state, loss timer and latched alarm code.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      pf_q       <= PF_IDLE;
      pf_ms_q    <= 16'h0000;
      alarm_code <= `TD_ALM_NONE;
    end else begin
      pf_q <= pf_d;
      if (pf_q != PF_RIDE) begin
        pf_ms_q <= 16'h0000;
      end else if (tick_q && pf_ms_q != 16'hffff) begin
        pf_ms_q <= pf_ms_q + 16'h0001;
      end
      if (pf_d == PF_ALARM && pf_q != PF_ALARM) begin
        alarm_code <= (pf_q == PF_RIDE && uv_q) ? `TD_ALM_UV
                                                : `TD_ALM_PF;
      end else if (pf_d == PF_IDLE) begin
        alarm_code <= `TD_ALM_NONE;
      end
    end
  end

  // Brake stays held through ride-through; torque is trimmed for
  // overload and for a heavy load while living off the capacitor.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      brake_interlock <= 1'b0;
      torque_limit    <= `TD_FULL_PCT;
    end else begin
      brake_interlock <= brake_request | (pf_q == PF_RIDE);
      if (ol_cond) begin
        torque_limit <= `TD_OL_TARGET;
      end else if (pf_q == PF_RIDE && load_ratio > `TD_PF_LOAD_LIM) begin
        torque_limit <= `TD_PF_TORQUE;
      end else begin
        torque_limit <= `TD_FULL_PCT;
      end
    end
  end

  // Event counter: each start adds one, several starts in one cycle
  // add one each, and the count wraps.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      events_q <= 16'h0000;
    end else begin
      events_q <= events_q + {15'h0000, ol_start}
                           + {15'h0000, vib_hit}
                           + {15'h0000, pf_start};
    end
  end
endmodule // td_supervisor

// ===== sim/td_checker.sv
`timescale 1ns/1ns
// Watches the supervisor ports for bus, gating and commit relations.
module td_checker #(
  parameter [16:0] TICK_CYCLES = 17'h1_86a0,
  parameter [21:0] HOUR_TICKS  = 22'h36_ee80
) (
  // Clock and reset.
  input wire logic        clk_sys,
  input wire logic        reset,
  // Bus handshake.
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // Drive state.
  input wire logic        pos_mode,
  input wire logic [7:0]  load_ratio,
  input wire logic        motor_stopped,
  input wire logic        in_position_raw,
  input wire logic        zero_speed_raw,
  input wire logic        brake_request,
  // Status outputs.
  input wire logic        in_position,
  input wire logic        zero_speed,
  input wire logic        tough_drive_active,
  input wire logic        brake_interlock,
  input wire logic [7:0]  torque_limit,
  input wire logic [11:0] alarm_code,
  input wire logic        nv_write
);
  // One tick of slack, since the hour count starts at the commit, not on a tick boundary.
  localparam int GAP = (HOUR_TICKS - 1) * TICK_CYCLES;
  logic [31:0] gap_q;  // Cycles since the last commit, saturating.
  // Count from each commit so the spacing can be judged.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      gap_q <= 32'hffff_ffff;
    end else if (nv_write) begin
      gap_q <= 32'h0;
    end else if (gap_q != 32'hffff_ffff) begin
      gap_q <= gap_q + 32'h1;
    end
  end
  default clocking dc @(posedge clk_sys); endclocking
  default disable iff (reset);
  chk_ack_prompt: assert property ($rose(wb_cyc_i && wb_stb_i) |=> wb_ack_o)
    else $error("ack missing one cycle after request");
  chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  chk_ol_mode: assert property (!pos_mode [*3] |-> !tough_drive_active)
    else $error("active flag outside position mode");
  chk_ol_spike: assert property ((load_ratio > 8'hc8) [*3]
    |-> !tough_drive_active) else $error("active flag during spike");
  chk_ol_stop: assert property (motor_stopped [*3] |-> !tough_drive_active)
    else $error("active flag while stopped");
  chk_ol_torque: assert property (tough_drive_active
    && $past(tough_drive_active) |-> torque_limit == 8'h46)
    else $error("torque not cut while overload active");
  chk_inpos_drop: assert property (!in_position_raw |=> !in_position)
    else $error("in position high after raw low");
  chk_zspd_drop: assert property (!zero_speed_raw |=> !zero_speed)
    else $error("zero speed high after raw low");
  chk_brake_hold: assert property (brake_request ##1 brake_request
    |-> brake_interlock) else $error("brake interlock released");
  chk_alarm_set: assert property (alarm_code inside
    {12'h000, 12'h102, 12'h103}) else $error("unknown alarm code");
  chk_nv_pulse: assert property (nv_write |=> !nv_write)
    else $error("commit pulse too long");
  chk_nv_space: assert property (nv_write |-> gap_q >= GAP)
    else $error("commits closer than the hour spacing");
endmodule  // td_checker

bind td_supervisor td_checker #(
  .TICK_CYCLES(TICK_CYCLES), .HOUR_TICKS(HOUR_TICKS)
) td_checker_inst (
  .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .pos_mode(pos_mode),
  .load_ratio(load_ratio), .motor_stopped(motor_stopped),
  .in_position_raw(in_position_raw), .zero_speed_raw(zero_speed_raw),
  .brake_request(brake_request), .in_position(in_position),
  .zero_speed(zero_speed), .tough_drive_active(tough_drive_active),
  .brake_interlock(brake_interlock), .torque_limit(torque_limit),
  .alarm_code(alarm_code), .nv_write(nv_write)
);

// ===== sim/td_host_model.sv
`timescale 1ns/1ns
// Host controller: starts a move, then withholds its next command until
// the gated in-position output comes up.
module td_host_model #(
  parameter int MOVE = 8
) (
  // Clock and reset.
  input  wire logic clk_sys,
  input  wire logic reset,
  // Command start and the status it watches.
  input  wire logic go,
  input  wire logic in_position,
  // Motion status for the servo core inputs.
  output logic      in_position_raw,
  output logic      zero_speed_raw,
  output logic      busy,
  output int        waited
);
  int phase_q;  // Move cycles left; zero once the axis has settled.
  assign zero_speed_raw = in_position_raw;
  // A go while busy is ignored, so commands never overlap.
  always @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      in_position_raw <= 1'b1;
      busy <= 1'b0;
      waited <= 0;
      phase_q <= 0;
    end else if (go && !busy) begin
      busy <= 1'b1;
      phase_q <= MOVE;
      in_position_raw <= 1'b0;
      waited <= 0;
    end else if (phase_q > 1) begin
      phase_q <= phase_q - 1;
    end else if (phase_q == 1) begin
      phase_q <= 0;
      in_position_raw <= 1'b1;
    end else if (busy) begin
      if (in_position) busy <= 1'b0;
      else waited <= waited + 1;
    end
  end
endmodule  // td_host_model

// ===== sim/testbench.sv
`timescale 1ns/1ns
// Self-checking bench for the tough drive supervisor.
module testbench;
  logic        clk_sys = 0, reset = 1, cyc = 0, stb = 0, we = 0, go = 0;
  logic        pos_mode = 0, motor_stopped = 0, brake_request = 0;
  logic        res_valid = 0, mains_ok = 1, bus_uv = 0;
  logic        ack, busy, in_pos, zero_spd, tda, brake, nv_write;
  logic        inp_raw, zsp_raw;
  logic [3:0]  sel = 4'hf;
  logic [7:0]  adr = 0, load = 0, torque;
  logic [11:0] alarm;
  logic [15:0] res_freq = 0, res_level = 0, nv1, nv2;
  logic [31:0] wdat = 0, rdat, q;
  int          mismatches = 0, cmp_count = 0, waited, nv_cnt = 0;
  // Rows: write flag, address, write data, expected read-back.
  logic [72:0] rows [0:14] = '{
    {1'b0, 8'h00, 32'h0, 32'h0}, {1'b0, 8'h04, 32'h0, 32'h1f4},
    {1'b0, 8'h08, 32'h0, 32'h32}, {1'b0, 8'h0c, 32'h0, 32'h14},
    {1'b0, 8'h10, 32'h0, 32'h1194}, {1'b0, 8'h14, 32'h0, 32'h1194},
    {1'b0, 8'h18, 32'h0, 32'h1194}, {1'b0, 8'h1c, 32'h0, 32'h0},
    {1'b0, 8'h20, 32'h0, 32'h1000}, {1'b1, 8'h24, 32'hdead, 32'h0},
    {1'b1, 8'h1c, 32'hffff, 32'h0}, {1'b1, 8'h04, 32'h5, 32'h5},
    {1'b1, 8'h0c, 32'h5, 32'h5}, {1'b1, 8'h08, 32'hffff_0028, 32'h28},
    {1'b1, 8'h00, 32'h7, 32'h3}};
  // Short tick and hour so the timed paths fit in the run.
  td_supervisor #(.TICK_CYCLES(17'ha), .HOUR_TICKS(22'h14))
    td_supervisor_inst (
    .clk_sys(clk_sys), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .pos_mode(pos_mode),
    .load_ratio(load), .motor_stopped(motor_stopped),
    .in_position_raw(inp_raw), .zero_speed_raw(zsp_raw),
    .brake_request(brake_request), .res_valid(res_valid),
    .res_freq(res_freq), .res_level(res_level), .mains_ok_pin(mains_ok),
    .bus_uv_pin(bus_uv), .in_position(in_pos), .zero_speed(zero_spd),
    .tough_drive_active(tda), .brake_interlock(brake),
    .torque_limit(torque), .alarm_code(alarm), .nv_write(nv_write),
    .nv_notch1(nv1), .nv_notch2(nv2));
  td_host_model td_host_model_inst (.clk_sys(clk_sys), .reset(reset),
    .go(go), .in_position(in_pos), .in_position_raw(inp_raw),
    .zero_speed_raw(zsp_raw), .busy(busy), .waited(waited));
  // Free-running 100 MHz clock.
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Commit pulses are counted here and read off the edge.
  always @(posedge clk_sys) if (nv_write === 1'b1) nv_cnt++;
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wrap_up;
    $display("Counts: %0d compares, %0d mismatches", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // One classic cycle; the request stands until ack is sampled high.
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) begin
      mismatches++;
      wrap_up();
    end
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task automatic res(input logic [15:0] f, input logic [15:0] l);
    @(posedge clk_sys);
    res_valid <= 1'b1;
    res_freq <= f;
    res_level <= l;
    @(posedge clk_sys) res_valid <= 1'b0;
  endtask
  // Runs one host move; q keeps both gated outputs mid-way.
  task automatic move(input int mid);
    int n;
    n = 0;
    @(posedge clk_sys) go <= 1'b1;
    @(posedge clk_sys) go <= 1'b0;
    tk(mid);
    q = {30'h0, in_pos, zero_spd};
    while (busy === 1'b1 && n < 200) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 200) begin
      mismatches++;
      wrap_up();
    end
  endtask
  initial begin
    tk(10);
    @(posedge clk_sys) reset <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i][72]) wb(1'b1, rows[i][71:64], rows[i][63:32]);
      rd(rows[i][71:64], rows[i][31:0]);
    end
    $display("Test registers done");
    @(posedge clk_sys) pos_mode <= 1'b1;
    load <= 8'h96;
    tk(4);
    chk(tda, 1'b1);
    chk(torque, 8'h46);
    rd(8'h20, 32'h9000);
    move(20);
    chk(q, 32'h0);
    chk(waited >= 38 && waited <= 65, 1'b1);
    @(posedge clk_sys) load <= 8'hd2;
    tk(4);
    chk(tda, 1'b0);
    @(posedge clk_sys) load <= 8'h32;
    tk(4);
    chk(tda, 1'b0);
    move(20);
    chk(waited <= 3, 1'b1);
    wb(1'b1, 8'h00, 32'h1);
    @(posedge clk_sys) load <= 8'h96;
    tk(4);
    chk(tda, 1'b0);
    rd(8'h20, 32'h9000);
    @(posedge clk_sys) pos_mode <= 1'b0;
    rd(8'h20, 32'h1000);
    @(posedge clk_sys) pos_mode <= 1'b1;
    motor_stopped <= 1'b1;
    rd(8'h20, 32'h1000);
    wb(1'b1, 8'h00, 32'h0);
    @(posedge clk_sys) motor_stopped <= 1'b0;
    rd(8'h20, 32'h1000);
    @(posedge clk_sys) load <= 8'h32;
    wb(1'b1, 8'h00, 32'h3);
    rd(8'h1c, 32'h2);
    $display("Test overload done");
    res(16'h1388, 16'h0027);
    rd(8'h10, 32'h1194);
    res(16'h1f40, 16'h0028);
    rd(8'h10, 32'h1194);
    res(16'h16da, 16'h0028);
    rd(8'h10, 32'h16da);
    chk(nv1, 16'h16da);
    res(16'h1130, 16'h0028);
    rd(8'h14, 32'h1130);
    rd(8'h18, 32'h1194);
    tk(100);
    @(negedge clk_sys);
    chk(nv_cnt, 1);
    tk(150);
    @(negedge clk_sys);
    chk(nv_cnt, 2);
    chk(nv2, 16'h1130);
    rd(8'h1c, 32'h4);
    $display("Test vibration done");
    @(posedge clk_sys) brake_request <= 1'b1;
    tk(3);
    chk(brake, 1'b1);
    @(posedge clk_sys) brake_request <= 1'b0;
    @(posedge clk_sys) mains_ok <= 1'b0;
    load <= 8'h5a;
    tk(10);
    chk(brake, 1'b1);
    chk(torque, 8'h50);
    rd(8'h20, 32'h2000);
    @(posedge clk_sys) mains_ok <= 1'b1;
    tk(10);
    rd(8'h20, 32'h1000);
    chk(brake, 1'b0);
    @(posedge clk_sys) mains_ok <= 1'b0;
    tk(80);
    chk(alarm, 12'h103);
    rd(8'h20, 32'h4103);
    @(posedge clk_sys) mains_ok <= 1'b1;
    tk(8);
    wb(1'b1, 8'h00, 32'h7);
    @(posedge clk_sys) mains_ok <= 1'b0;
    tk(10);
    @(posedge clk_sys) bus_uv <= 1'b1;
    tk(8);
    chk(alarm, 12'h102);
    @(posedge clk_sys) bus_uv <= 1'b0;
    mains_ok <= 1'b1;
    tk(8);
    wb(1'b1, 8'h00, 32'h6);
    @(posedge clk_sys) mains_ok <= 1'b0;
    tk(10);
    chk(alarm, 12'h103);
    @(posedge clk_sys) mains_ok <= 1'b1;
    tk(8);
    wb(1'b1, 8'h00, 32'h7);
    chk(alarm, 12'h000);
    rd(8'h1c, 32'h7);
    $display("Test power done");
    @(posedge clk_sys) reset <= 1'b1;
    tk(3);
    @(posedge clk_sys) reset <= 1'b0;
    rd(8'h1c, 32'h0);
    rd(8'h00, 32'h0);
    $display("Test reset done");
    wrap_up();
  end
endmodule  // testbench
